// ===== csd_cfg.svh
/*
 * Offsets, field positions, reset values and nominal frequencies of the
 * system clock select and divide block.
 * Assumes it is included by bare name, once per compilation unit.
 */
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

`define CSD_ADDR_CLK_PRIMARY 32'h40002000
`define CSD_ADDR_PERIPH_DIV 32'h40002004
`define CSD_ADDR_PERIPH_GATE 32'h4000202C
`define CSD_ADDR_CLK_TERTIARY 32'h4000203C
`define CSD_ADDR_XTAL_CTRL 32'h40002410
`define CSD_ADDR_SYS_DIVIDE 32'h40002444

`define CSD_RST_CLK_PRIMARY 16'h0001
`define CSD_RST_PERIPH_DIV 16'hFFFF
`define CSD_RST_PERIPH_GATE 16'h0DFF
`define CSD_RST_CLK_TERTIARY 16'h7F07
`define CSD_RST_XTAL_CTRL 16'h0000
`define CSD_RST_SYS_DIVIDE 16'h0063

`define CSD_CORE_DIV_LSB 0
`define CSD_CORE_DIV_MSB 2
`define CSD_SRC_SEL_LSB 3
`define CSD_SRC_SEL_MSB 4
`define CSD_CLOCK_OUT_SELECT_LSB 5
`define CSD_CLOCK_OUT_SELECT_MSB 7
`define CSD_SYS_DIV_LSB 0
`define CSD_SYS_DIV_MSB 1
`define CSD_GATE_DMA_BIT 8
`define CSD_GATE_ADC_BIT 9
`define CSD_GATE_COUNT 10

`define CSD_CLK_FREQ_HZ 100000000
`define CSD_HIGH_FREQ_INTERNAL_OSC_NOM_HZ 16000000
`define CSD_LOW_FREQ_INTERNAL_OSC_NOM_HZ 32000

`endif

// ===== csd_pkg.sv
/*
 * Types shared by the system clock select and divide block.
 * Assumes csd_cfg.svh is available on the include path.
 */
package csd_pkg;

    typedef logic [31:0] csd_addr_t;
    typedef logic [15:0] csd_data_t;
    typedef logic [2:0] csd_div_code_t;

    typedef enum logic [1:0] {
        CSD_SRC_HIGH_FREQ_INTERNAL_OSC = 2'h0,
        CSD_SRC_XTAL = 2'h1,
        CSD_SRC_LOW_FREQ_INTERNAL_OSC = 2'h2,
        CSD_SRC_EXT = 2'h3
    } csd_src_e;

    typedef enum logic [2:0] {
        CSD_OUT_BASE0 = 3'h0,
        CSD_OUT_BASE1 = 3'h1,
        CSD_OUT_PERIPH = 3'h2,
        CSD_OUT_RSV0 = 3'h3,
        CSD_OUT_RSV1 = 3'h4,
        CSD_OUT_HIGH_FREQ_INTERNAL_OSC = 3'h5,
        CSD_OUT_LOW_FREQ_INTERNAL_OSC = 3'h6,
        CSD_OUT_XTAL = 3'h7
    } csd_out_e;

endpackage : csd_pkg

// ===== csd_tick_div.sv
/*
 * Power-of-two divider of a one-cycle tick stream.
 * Assumes tick_in is a one-cycle enable on the same clock; the code
 * may change at any time and is taken up only at a period boundary.
 */
`timescale 1ns/1ns

module csd_tick_div (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tick_in,
    input wire csd_pkg::csd_div_code_t code,
    input wire csd_pkg::csd_div_code_t reset_code,
    output logic tick_out
);
    import csd_pkg::*;

    logic [6:0] count_q;
    csd_div_code_t active_q;
    logic wrap;

    function automatic logic [6:0] csd_mask(input csd_div_code_t c);
        csd_mask = 7'((8'h01 << c) - 8'h01);
    endfunction : csd_mask

    assign wrap = tick_in && (count_q == csd_mask(active_q));

    ////////////////////////////////////////////////////////////////////////
    // A new ratio is only adopted at wrap, so no period is ever cut short.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 7'h00;
        end else if (wrap) begin
            count_q <= 7'h00;
        end else if (tick_in) begin
            count_q <= 7'(count_q + 7'h01);
        end
    end

    // The reset code is a constant at the instance, caught after release.
    logic loaded_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            loaded_q <= 1'b0;
            active_q <= 3'h0;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            active_q <= reset_code;
        end else if (wrap) begin
            active_q <= code;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= wrap && loaded_q;
        end
    end

endmodule : csd_tick_div

// ===== csd_clock_ctrl.sv
/*
 * System clock select and divide block: source selection, base and core
 * divide, derived clock enables, test clock out and peripheral gating.
 * Assumes oscillator and pin inputs are asynchronous and far slower than
 * clock, and that software drives the memory-mapped register port.
 */
`timescale 1ns/1ns
`include "csd_cfg.svh"

module csd_clock_ctrl (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic high_freq_internal_osc,
    input wire logic low_freq_internal_osc,
    input wire logic low_freq_crystal,
    input wire logic external_clock_input,
    input wire csd_pkg::csd_addr_t reg_addr,
    input wire logic reg_write,
    input wire csd_pkg::csd_data_t reg_wdata,
    input wire logic reg_read,
    output csd_pkg::csd_data_t reg_rdata,
    output logic core_clock_tick,
    output logic base_system_clock_tick,
    output logic memory_clock_tick,
    output logic analog_clock_tick,
    output logic periph_clock_tick,
    output logic [`CSD_GATE_COUNT-1:0] periph_clock_enable,
    output logic clock_out,
    output csd_pkg::csd_data_t periph_divide_out,
    output csd_pkg::csd_data_t clock_tertiary_out,
    output csd_pkg::csd_data_t crystal_ctrl_out
);
    import csd_pkg::*;

    csd_data_t clock_control_primary_q;
    csd_data_t peripheral_divide_control_q;
    csd_data_t peripheral_clock_gate_q;
    csd_data_t clock_control_tertiary_q;
    csd_data_t crystal_osc_control_q;
    csd_data_t system_divide_setting_q;

    ////////////////////////////////////////////////////////////////////////
    // Register port.
    function automatic logic csd_hit(input csd_addr_t a, input csd_addr_t b);
        csd_hit = (a == b);
    endfunction : csd_hit

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clock_control_primary_q <= `CSD_RST_CLK_PRIMARY;
            peripheral_divide_control_q <= `CSD_RST_PERIPH_DIV;
            peripheral_clock_gate_q <= `CSD_RST_PERIPH_GATE;
            clock_control_tertiary_q <= `CSD_RST_CLK_TERTIARY;
            crystal_osc_control_q <= `CSD_RST_XTAL_CTRL;
            system_divide_setting_q <= `CSD_RST_SYS_DIVIDE;
        end else if (reg_write) begin
            if (csd_hit(reg_addr, `CSD_ADDR_CLK_PRIMARY)) begin
                clock_control_primary_q <= reg_wdata;
            end
            if (csd_hit(reg_addr, `CSD_ADDR_PERIPH_DIV)) begin
                peripheral_divide_control_q <= reg_wdata;
            end
            if (csd_hit(reg_addr, `CSD_ADDR_PERIPH_GATE)) begin
                peripheral_clock_gate_q <= reg_wdata;
            end
            if (csd_hit(reg_addr, `CSD_ADDR_CLK_TERTIARY)) begin
                clock_control_tertiary_q <= reg_wdata;
            end
            if (csd_hit(reg_addr, `CSD_ADDR_XTAL_CTRL)) begin
                crystal_osc_control_q <= reg_wdata;
            end
            if (csd_hit(reg_addr, `CSD_ADDR_SYS_DIVIDE)) begin
                system_divide_setting_q <= reg_wdata;
            end
        end
    end

    // Read data is registered; an unmapped address reads as zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            if (csd_hit(reg_addr, `CSD_ADDR_CLK_PRIMARY)) begin
                reg_rdata <= clock_control_primary_q;
            end else if (csd_hit(reg_addr, `CSD_ADDR_PERIPH_DIV)) begin
                reg_rdata <= peripheral_divide_control_q;
            end else if (csd_hit(reg_addr, `CSD_ADDR_PERIPH_GATE)) begin
                reg_rdata <= peripheral_clock_gate_q;
            end else if (csd_hit(reg_addr, `CSD_ADDR_CLK_TERTIARY)) begin
                reg_rdata <= clock_control_tertiary_q;
            end else if (csd_hit(reg_addr, `CSD_ADDR_XTAL_CTRL)) begin
                reg_rdata <= crystal_osc_control_q;
            end else if (csd_hit(reg_addr, `CSD_ADDR_SYS_DIVIDE)) begin
                reg_rdata <= system_divide_setting_q;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            periph_divide_out <= `CSD_RST_PERIPH_DIV;
            clock_tertiary_out <= `CSD_RST_CLK_TERTIARY;
            crystal_ctrl_out <= `CSD_RST_XTAL_CTRL;
        end else begin
            periph_divide_out <= peripheral_divide_control_q;
            clock_tertiary_out <= clock_control_tertiary_q;
            crystal_ctrl_out <= crystal_osc_control_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator inputs: two-stage synchronisers, then rising-edge ticks.
    // The sources must stay well below half of clock, or edges are lost.
    logic [3:0] osc_meta_q;
    logic [3:0] osc_sync_q;
    logic [3:0] osc_prev_q;
    logic [3:0] osc_tick;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            osc_meta_q <= 4'h0;
            osc_sync_q <= 4'h0;
        end else begin
            osc_meta_q <= {external_clock_input, low_freq_internal_osc,
                low_freq_crystal, high_freq_internal_osc};
            osc_sync_q <= osc_meta_q;
        end
    end

    // The edge history reads only the second stage; the first stage may
    // be metastable and is read by nothing but the second.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            osc_prev_q <= 4'h0;
        end else begin
            osc_prev_q <= osc_sync_q;
        end
    end

    assign osc_tick = osc_sync_q & ~osc_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Source selection. The shared pin need not already carry a clock
    // when the external source is picked; the switch waits for its first edge.
    csd_src_e src_req;
    csd_src_e src_active_q;
    logic src_tick;

    assign src_req = csd_src_e'(
        clock_control_primary_q[`CSD_SRC_SEL_MSB:`CSD_SRC_SEL_LSB]);

    // Switching waits for an edge of the new source, so old ticks stop at that
    // edge and the new period starts whole; a dead source is not taken.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            src_active_q <= CSD_SRC_HIGH_FREQ_INTERNAL_OSC;
        end else if (src_req != src_active_q && osc_tick[src_req]) begin
            src_active_q <= src_req;
        end
    end

    assign src_tick = osc_tick[src_active_q] && (src_active_q == src_req ||
                      !osc_tick[src_req]);

    ////////////////////////////////////////////////////////////////////////
    // Base and core dividers.
    logic base_tick;
    logic core_tick;
    csd_div_code_t sys_code;

    assign sys_code = {1'b0,
        system_divide_setting_q[`CSD_SYS_DIV_MSB:`CSD_SYS_DIV_LSB]};

    // Divider codes at reset are cut from the register reset values, so
    // the dividers and the registers cannot disagree after a reset.
    localparam csd_data_t SYS_RESET = `CSD_RST_SYS_DIVIDE;
    localparam csd_data_t PRIM_RESET = `CSD_RST_CLK_PRIMARY;
    localparam csd_div_code_t SYS_CODE_RESET =
        {1'b0, SYS_RESET[`CSD_SYS_DIV_MSB:`CSD_SYS_DIV_LSB]};
    localparam csd_div_code_t CORE_CODE_RESET =
        PRIM_RESET[`CSD_CORE_DIV_MSB:`CSD_CORE_DIV_LSB];

    csd_tick_div u_base_div (
        .clock(clock),
        .reset_n(reset_n),
        .tick_in(src_tick),
        .code(sys_code),
        .reset_code(SYS_CODE_RESET),
        .tick_out(base_tick)
    );

    csd_tick_div u_core_div (
        .clock(clock),
        .reset_n(reset_n),
        .tick_in(base_tick),
        .code(clock_control_primary_q[`CSD_CORE_DIV_MSB:`CSD_CORE_DIV_LSB]),
        .reset_code(CORE_CODE_RESET),
        .tick_out(core_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Derived clock enables and peripheral gates. The peripheral clock is
    // the base clock; its own ratios are left to the peripherals, which
    // rely on software keeping them at or above the core rate.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_clock_tick <= 1'b0;
            base_system_clock_tick <= 1'b0;
            memory_clock_tick <= 1'b0;
            analog_clock_tick <= 1'b0;
            periph_clock_tick <= 1'b0;
        end else begin
            core_clock_tick <= core_tick;
            base_system_clock_tick <= base_tick;
            memory_clock_tick <= core_tick &&
                !peripheral_clock_gate_q[`CSD_GATE_DMA_BIT];
            analog_clock_tick <= base_tick &&
                !peripheral_clock_gate_q[`CSD_GATE_ADC_BIT];
            periph_clock_tick <= base_tick;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            periph_clock_enable <= '0;
        end else begin
            periph_clock_enable <= {`CSD_GATE_COUNT{base_tick}} &
                ~peripheral_clock_gate_q[`CSD_GATE_COUNT-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test clock out: toggles on each tick of the chosen clock, so its
    // frequency is half the tick rate. Meant for test only.
    csd_out_e out_sel;
    csd_out_e out_sel_q;
    logic [1:0] out_quiet_q;
    logic out_pick;
    logic out_tick;

    assign out_sel = csd_out_e'(
        clock_control_primary_q[`CSD_CLOCK_OUT_SELECT_MSB:`CSD_CLOCK_OUT_SELECT_LSB]);

    // A new selection waits out four quiet cycles, so a tick of the old
    // clock and one of the new clock never toggle the output back to back.
    // A tick that falls in the quiet cycles is lost, so one period runs long.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_sel_q <= CSD_OUT_BASE0;
        end else begin
            out_sel_q <= out_sel;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_quiet_q <= 2'h0;
        end else if (out_sel != out_sel_q) begin
            out_quiet_q <= 2'h3;
        end else if (out_quiet_q != 2'h0) begin
            out_quiet_q <= 2'(out_quiet_q - 2'h1);
        end
    end

    always_comb begin
        case (out_sel_q)
            CSD_OUT_BASE0: out_pick = base_tick;
            CSD_OUT_BASE1: out_pick = base_tick;
            CSD_OUT_PERIPH: out_pick = base_tick;
            CSD_OUT_HIGH_FREQ_INTERNAL_OSC: out_pick = osc_tick[CSD_SRC_HIGH_FREQ_INTERNAL_OSC];
            CSD_OUT_LOW_FREQ_INTERNAL_OSC: out_pick = osc_tick[CSD_SRC_LOW_FREQ_INTERNAL_OSC];
            CSD_OUT_XTAL: out_pick = osc_tick[CSD_SRC_XTAL];
            default: out_pick = 1'b0;
        endcase
    end

    assign out_tick = out_pick && out_quiet_q == 2'h0 &&
        out_sel == out_sel_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clock_out <= 1'b0;
        end else if (out_tick) begin
            clock_out <= !clock_out;
        end
    end

endmodule : csd_clock_ctrl

// ===== csd_clock_ctrl_props.sv
/* Port checker of csd_clock_ctrl: tick spacing, register port, copies.
 * Assumes oscillators far slower than clock and a bind to the top. */
`timescale 1ns/1ns
`include "csd_cfg.svh"

module csd_clock_ctrl_props (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic high_freq_internal_osc,
    input wire logic low_freq_internal_osc,
    input wire logic low_freq_crystal,
    input wire logic external_clock_input,
    input wire csd_pkg::csd_addr_t reg_addr,
    input wire logic reg_write,
    input wire csd_pkg::csd_data_t reg_wdata,
    input wire logic reg_read,
    input wire csd_pkg::csd_data_t reg_rdata,
    input wire logic core_clock_tick,
    input wire logic base_system_clock_tick,
    input wire logic memory_clock_tick,
    input wire logic analog_clock_tick,
    input wire logic periph_clock_tick,
    input wire logic [`CSD_GATE_COUNT-1:0] periph_clock_enable,
    input wire logic clock_out,
    input wire csd_pkg::csd_data_t periph_divide_out,
    input wire csd_pkg::csd_data_t clock_tertiary_out,
    input wire csd_pkg::csd_data_t crystal_ctrl_out
);
    import csd_pkg::*;
    localparam csd_addr_t PRIM = `CSD_ADDR_CLK_PRIMARY;
    localparam csd_addr_t PDIV = `CSD_ADDR_PERIPH_DIV;
    localparam csd_addr_t XTAL = `CSD_ADDR_XTAL_CTRL;
    logic mapped;
    assign mapped = reg_addr inside {PRIM, PDIV, XTAL,
        `CSD_ADDR_PERIPH_GATE, `CSD_ADDR_CLK_TERTIARY, `CSD_ADDR_SYS_DIVIDE};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////
    core_gap_a: assert property (
        core_clock_tick |=> (!core_clock_tick) [*3])
        else $error("core tick too close");
    base_gap_a: assert property (
        base_system_clock_tick |=> (!base_system_clock_tick) [*3])
        else $error("base tick too close");
    core_after_a: assert property (
        core_clock_tick |-> base_system_clock_tick
        || $past(base_system_clock_tick) || $past(base_system_clock_tick, 2))
        else $error("core tick without base tick");
    gate_subset_a: assert property (
        (|periph_clock_enable) |-> periph_clock_tick)
        else $error("peripheral enable off the base tick");
    analog_tick_a: assert property (
        analog_clock_tick |-> periph_clock_tick)
        else $error("analog tick off the base tick");
    rdata_hold_a: assert property (
        !$past(reg_read) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (
        reg_read && !mapped |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    readback_a: assert property (
        reg_write && reg_addr == PRIM ##2 reg_read && !reg_write
        && reg_addr == PRIM && !$past(reg_write)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("primary read back wrong");
    copy_div_a: assert property (
        reg_write && reg_addr == PDIV |-> ##2
        periph_divide_out == $past(reg_wdata, 2))
        else $error("divide copy wrong");
    copy_xtal_a: assert property (
        reg_write && reg_addr == XTAL |-> ##2
        crystal_ctrl_out == $past(reg_wdata, 2))
        else $error("crystal copy wrong");
    out_glitch_a: assert property (
        $changed(clock_out) |=> $stable(clock_out) [*2])
        else $error("clock out glitch");
    cover property (core_clock_tick);
    cover property (reg_read && !mapped);
    cover property ($changed(clock_out));
endmodule : csd_clock_ctrl_props

bind csd_clock_ctrl csd_clock_ctrl_props u_props (
    .clock, .reset_n, .high_freq_internal_osc, .low_freq_internal_osc,
    .low_freq_crystal, .external_clock_input, .reg_addr, .reg_write,
    .reg_wdata, .reg_read, .reg_rdata, .core_clock_tick,
    .base_system_clock_tick, .memory_clock_tick, .analog_clock_tick,
    .periph_clock_tick, .periph_clock_enable, .clock_out,
    .periph_divide_out, .clock_tertiary_out, .crystal_ctrl_out
);

// ===== csd_clock_ctrl_bench.sv
/* Self-checking bench of csd_clock_ctrl: rows of divide settings, then
 * reset values, register access, reserved codes and gating.
 * Assumes csd_pkg and the design files are compiled before it. */
`timescale 1ns/1ns
`include "csd_cfg.svh"

module csd_clock_ctrl_bench;
    import csd_pkg::*;
    typedef struct {csd_data_t prim; csd_data_t sdiv; int s; int p;} csd_row_s;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] osc = 4'h0;
    int cnt [4] = '{default: 0};
    int half [4] = '{4, 6, 10, 14};
    int sper [4] = '{8, 12, 20, 28};
    int osel [6] = '{0, 1, 2, 5, 6, 7};
    int oexp [6] = '{32, 32, 32, 16, 40, 24};
    csd_addr_t ra [6] = '{`CSD_ADDR_CLK_PRIMARY, `CSD_ADDR_PERIPH_DIV,
        `CSD_ADDR_PERIPH_GATE, `CSD_ADDR_CLK_TERTIARY, `CSD_ADDR_XTAL_CTRL,
        `CSD_ADDR_SYS_DIVIDE};
    csd_data_t rv [6] = '{`CSD_RST_CLK_PRIMARY, `CSD_RST_PERIPH_DIV,
        `CSD_RST_PERIPH_GATE, `CSD_RST_CLK_TERTIARY, `CSD_RST_XTAL_CTRL,
        `CSD_RST_SYS_DIVIDE};
    csd_addr_t addr = 32'h00000000;
    csd_data_t wd = 16'h0000;
    logic we = 1'b0;
    logic rd = 1'b0;
    csd_data_t rdata, pdo, cto, xco;
    logic core, base, mem, ana, ptk, cout;
    logic [9:0] en;
    logic [15:0] mon, prev;
    csd_row_s rows [$];
    int fails = 0;
    int checks_done = 0;
    always #5 clock = ~clock;
    assign mon = {ptk, en, mem, ana, cout, base, core};
    always @(negedge clock) prev <= mon;
    // Free-running sources with distinct periods of 8, 12, 20, 28 cycles.
    always @(negedge clock) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= (cnt[i] + 1 >= half[i]) ? 0 : cnt[i] + 1;
            if (cnt[i] + 1 >= half[i]) osc[i] <= ~osc[i];
        end
    end
    csd_clock_ctrl dut (.clock(clock), .reset_n(reset_n),
        .high_freq_internal_osc(osc[0]), .low_freq_crystal(osc[1]),
        .low_freq_internal_osc(osc[2]), .external_clock_input(osc[3]),
        .reg_addr(addr), .reg_write(we), .reg_wdata(wd), .reg_read(rd),
        .reg_rdata(rdata), .core_clock_tick(core),
        .base_system_clock_tick(base), .memory_clock_tick(mem),
        .analog_clock_tick(ana), .periph_clock_tick(ptk),
        .periph_clock_enable(en), .clock_out(cout),
        .periph_divide_out(pdo), .clock_tertiary_out(cto),
        .crystal_ctrl_out(xco));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input csd_addr_t a, input csd_data_t d);
        @(negedge clock);
        addr = a;
        wd = d;
        we = 1'b1;
        @(negedge clock);
        we = 1'b0;
    endtask : wr
    task automatic rd_reg(input csd_addr_t a, output csd_data_t v);
        @(negedge clock);
        addr = a;
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        v = rdata;
    endtask : rd_reg
    // Cycles up to the next rise of one watched output, capped at 5000.
    task automatic gap(input int s, output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!(mon[s] === 1'b1 && prev[s] === 1'b0) && n < 5000);
    endtask : gap
    // Two gaps are skipped so a new ratio has been taken up at a wrap.
    task automatic per(input int s, output int n);
        repeat (3) gap(s, n);
    endtask : per
    task automatic watch(output logic [11:0] seen);
        seen = 12'h000;
        repeat (300) begin
            @(negedge clock);
            seen |= {mem, ana, en};
        end
    endtask : watch
    task automatic summarize;
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        csd_data_t v, w;
        logic [11:0] seen;
        for (int c = 0; c < 8; c++)
            rows.push_back('{csd_data_t'(c), 16'h0, 0, 8 << c});
        for (int d = 0; d < 4; d++)
            rows.push_back('{16'h0, csd_data_t'(d), 1, 8 << d});
        // The peripheral tick runs with the base clock, never below core.
        rows.push_back('{16'h0, 16'h2, 15, 32});
        // The external source already runs before it is selected.
        for (int k = 0; k < 4; k++)
            rows.push_back('{csd_data_t'(k << 3), 16'h0, 0, sper[k]});
        for (int i = 0; i < 6; i++)
            rows.push_back('{csd_data_t'(osel[i] << 5), 16'h1, 2, oexp[i]});
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        foreach (rows[i]) begin
            wr(`CSD_ADDR_CLK_PRIMARY, rows[i].prim);
            wr(`CSD_ADDR_SYS_DIVIDE, rows[i].sdiv);
            per(rows[i].s, n);
            check(n, rows[i].p);
        end
        reset_n = 1'b0;
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        check({pdo ^ rv[1], cto ^ rv[3], xco ^ rv[4]}, 48'h0);
        foreach (ra[i]) begin
            rd_reg(ra[i], v);
            check(v, rv[i]);
        end
        per(0, n);
        check(n, 128);
        per(1, n);
        check(n, 64);
        foreach (ra[i]) begin
            w = ~rv[i];
            wr(ra[i], w);
            rd_reg(ra[i], v);
            check(v, w);
        end
        check({pdo ^ rv[1], cto ^ rv[3], xco ^ rv[4]},
            48'hFFFF_FFFF_FFFF);
        wr(32'h40002008, 16'hA5A5);
        rd_reg(32'h40002008, v);
        check(v, 16'h0000);
        // Reserved clock-out codes must leave the output still.
        for (int c = 3; c < 5; c++) begin
            wr(`CSD_ADDR_CLK_PRIMARY, csd_data_t'(c << 5));
            gap(2, n);
            check(n, 5000);
        end
        wr(`CSD_ADDR_CLK_PRIMARY, 16'h0001);
        wr(`CSD_ADDR_SYS_DIVIDE, 16'h0000);
        wr(`CSD_ADDR_PERIPH_GATE, 16'h0155);
        watch(seen);
        check(seen, 12'h6AA);
        wr(`CSD_ADDR_PERIPH_GATE, 16'h02AA);
        watch(seen);
        check(seen, 12'h955);
        summarize();
    end
    initial begin
        #400000;
        fails++;
        summarize();
    end
endmodule : csd_clock_ctrl_bench
